// ==== bench/periph_model.sv ====
/* Peripheral stand-in: decoder, registers A, B, C, channel data.
   Assumes pull-ups on the data lines; a 1 in drive is released. */
`timescale 1ns/100ps
`default_nettype none
module periph_model (
   input wire logic             clk_link,
   input wire logic [3:0]       function_code,
   input wire logic             function_strobe,
   input wire logic [15:0]      d_i,
   input wire logic [15:0]      src,
   output var logic [15:0]      drive,
   output var logic [3:0][15:0] r
);
   wire logic [3:0] c = {function_code[0], function_code[1], function_code[2], function_code[3]};
   // pull low only under input codes
   always_comb begin
      case (c)
         4'h1, 4'h3, 4'h5: drive = r[c[2:1]];
         4'hC: drive = r[3];
         4'h9, 4'hA, 4'hB: drive = src;
         default: drive = 16'hFFFF;
      endcase
   end
   always @(posedge clk_link) begin
      if (!function_strobe) begin
         case (c)
            4'h0, 4'h2, 4'h4: r[c[2:1]] <= d_i;
            4'hD: r[3] <= d_i;
            4'h9: r <= '0;
            default: ;
         endcase
      end
   end
endmodule : periph_model
`default_nettype wire

// ==== bench/periph_port_checker.sv ====
/* Pin and handshake assertions for periph_port.
   Assumes binding to periph_port, seeing its ports only. */
`timescale 1ns/100ps
`default_nettype none
module periph_port_checker (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        clk_link,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic        cmd_done,
   input wire logic        rd_valid,
   input wire logic [15:0] d_oe_n,
   input wire logic [3:0]  function_code,
   input wire logic        function_strobe
);
   // Line 0 holds the leftmost printed bit
   wire logic [3:0] code = {function_code[0], function_code[1], function_code[2], function_code[3]};
   wire logic       drv  = ~&d_oe_n;
   wire logic       take = cmd_valid & cmd_ready;
   // Link reset trails rst_n by several master clocks
   logic [2:0] up_q = 3'h0;
   always @(posedge clk_link) up_q <= !rst_n ? 3'h0 : up_q + 3'(up_q != 3'h7);
   wire logic link_ok = (up_q == 3'h7);
   a_strobe_period: assert property (@(posedge clk_link) disable iff (!link_ok)
      $rose(function_strobe) |=> function_strobe ##1 !function_strobe [*2] ##1 function_strobe)
      else $error("strobe period wrong");
   a_code_at_rise: assert property (@(posedge clk_link) disable iff (!link_ok)
      $changed(function_code) |-> $rose(function_strobe)) else $error("code moved off rise");
   a_drive_codes: assert property (@(posedge clk_link) disable iff (!link_ok)
      drv |-> code inside {4'h0, 4'h2, 4'h4, 4'hD}) else $error("drive under wrong code");
   a_idle_quiet: assert property (@(posedge clk_link) disable iff (!link_ok)
      code == 4'hF |-> !drv) else $error("drive under idle code");
   a_drive_start: assert property (@(posedge clk_link) disable iff (!link_ok)
      $rose(drv) |-> $rose(function_strobe)) else $error("drive began off rise");
   a_drive_length: assert property (@(posedge clk_link) disable iff (!link_ok)
      $rose(drv) |=> drv [*3] ##1 !drv) else $error("drive not one strobe period");
   a_read_with_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_valid |-> cmd_done) else $error("read data without done");
   a_done_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take |-> ##[1:200] cmd_done) else $error("command never done");
   c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_valid);
   c_init: cover property (@(posedge clk_link) disable iff (!link_ok) code == 4'h9);
   c_chan_in: cover property (@(posedge clk_link) disable iff (!link_ok) code == 4'hC);
endmodule : periph_port_checker
bind periph_port periph_port_checker u_chk (.clk_sys, .rst_n, .clk_link, .cmd_valid,
   .cmd_ready, .cmd_done, .rd_valid, .d_oe_n, .function_code, .function_strobe);
`default_nettype wire

// ==== bench/tb_periph_port.sv ====
/* Self-checking bench for periph_port with a peripheral model.
   Assumes pull-ups on all sixteen data lines. */
`timescale 1ns/100ps
`default_nettype none
`define chk(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_periph_port;
   logic clk_sys = 0, clk_link = 1, rst_n = 0, cmd_valid = 0;
   periph_port_pkg::cmd_kind_t cmd_kind = periph_port_pkg::CMD_INSTR;
   logic [15:0] cmd_instr = 16'h0000, cmd_wdata = 16'h0000, src = 16'hFFFF;
   logic [15:0] rd_data, d_o, d_oe_n, drive, w;
   logic cmd_ready, cmd_done, rd_valid, polarity_negative, external_register_select;
   logic external_flag_logic_select, mask_bit, channel_dir_in, function_strobe;
   logic [4:0]  device_select_code, dev;
   logic [14:0] channel_addr;
   logic [3:0]  function_code;
   logic [3:0][15:0] r;
   logic [11:0] seq, e;
   wire logic [15:0] d_i = (~d_oe_n & d_o) | (d_oe_n & drive);
   int total_checks = 0, n_mismatch = 0, cyc = 0, o;
   logic [3:0] dc [8] = '{4'hF, 4'h1, 4'h0, 4'h3, 4'h2, 4'h5, 4'h4, 4'hF};
   int ops [8] = '{2, 1, 4, 3, 6, 5, 0, 7};
   periph_port uut (.*);
   periph_model peer (.*);
   always #50 clk_sys = ~clk_sys;
   always #62.5 clk_link = ~clk_link;
   always @(negedge function_strobe) if (rst_n && function_code != 4'hF)
      seq = {seq[7:0], function_code[0], function_code[1], function_code[2], function_code[3]};
   always @(posedge clk_sys) if (++cyc == 20000) begin n_mismatch++; end_of_test(); end
   task automatic run(input periph_port_pkg::cmd_kind_t k, input logic [15:0] i, v,
                      input logic [11:0] x);
      seq = 12'hFFF;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_instr = i;
      cmd_wdata = v;
      while (cmd_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      while (cmd_done !== 1'b1) @(negedge clk_sys);
      `chk("codes", x, seq)
   endtask : run
   task automatic ins(input int op, fn, input logic [15:0] v);
      e = 12'hFFF;
      if (op != 7 && dc[op] != 4'hF) e = {e[7:0], dc[op]};
      if (op != 7 && fn != 0) e = {e[7:0], 4'(5 + fn)};
      run(periph_port_pkg::CMD_INSTR, {5'h00, 3'(op), 2'(fn), 1'b0, dev}, v, e);
   endtask : ins
   task automatic init(input logic [15:0] s, input logic [7:0] x);
      src = s;
      run(periph_port_pkg::CMD_INIT, 16'h0000, 16'h0000, 12'hFF9);
      dev = x[7:3];
      `chk("init", x, {device_select_code, polarity_negative, external_register_select, external_flag_logic_select})
   endtask : init
   task automatic test_done(input string nm);
      $display("test %s done", nm);
   endtask : test_done
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (12) @(negedge clk_sys);
      `chk("idle", {1'b1, 4'hF, 16'hFFFF}, {cmd_ready, function_code, d_oe_n})
      init(16'hFF6A, {5'h15, 3'h2});
      for (int n = 0; n < 8; n++) begin
         o = ops[n];
         w = 16'hA5C3 + 16'(n);
         ins(o, n % 4, w);
         if (o inside {2, 4, 6}) `chk("load", w, r[o / 2 - 1])
         if (o inside {1, 3, 5}) `chk("read", {1'b1, w - 16'h0001}, {rd_valid, rd_data})
      end
      test_done("instructions");
      src = 16'h8000;
      run(periph_port_pkg::CMD_MASK, 16'h0000, 16'h0000, 12'hFFA);
      `chk("mask", 1'b1, mask_bit)
      src = 16'h4123;
      run(periph_port_pkg::CMD_CHAN_ADDR, 16'h0000, 16'h0000, 12'hFFB);
      `chk("dir out", 16'h4123, {channel_dir_in, channel_addr})
      run(periph_port_pkg::CMD_CHAN_XFER, 16'h0000, 16'h3C96, 12'hFFD);
      `chk("chan out", 16'h3C96, r[3])
      src = 16'hC001;
      run(periph_port_pkg::CMD_CHAN_ADDR, 16'h0000, 16'h0000, 12'hFFB);
      `chk("dir in", 16'hC001, {channel_dir_in, channel_addr})
      run(periph_port_pkg::CMD_CHAN_XFER, 16'h0000, 16'h0000, 12'hFFC);
      `chk("chan in", {1'b1, 16'h3C96}, {rd_valid, rd_data})
      run(periph_port_pkg::CMD_BLOCK_END, 16'h0000, 16'h0000, 12'hFFE);
      run(periph_port_pkg::CMD_INT_ACK, 16'h0000, 16'h0000, 12'hFFF);
      test_done("channel");
      init(16'hFEB5, {5'h0A, 3'h5});
      ins(2, 0, 16'h0FF0);
      `chk("neg load", 16'hF00F, r[0])
      ins(1, 0, 16'h0000);
      `chk("neg read", 16'h0FF0, rd_data)
      ins(3, 0, 16'h0000);
      `chk("ignored", 16'h0000, rd_data)
      test_done("polarity");
      end_of_test();
   end
endmodule : tb_periph_port
`default_nettype wire

// ==== src/level_sync.sv ====
/*
 * Three-flop level synchroniser; the output follows only once the second
 * and third stages agree. Assumes din is a level stable for several cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module level_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output var  logic dout
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d     = q;
      d.s1  = din;
      d.s2  = q.s1;
      d.s3  = q.s2;
      if (q.s2 == q.s3) begin
         d.out = q.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.out;

endmodule : level_sync

`default_nettype wire

// ==== src/periph_port.sv ====
/*
 * Peripheral port of a serial-bus I/O controller. Commands from the core
 * side (clk_sys) cross by toggle handshake to the link side (clk_link, the
 * master clock), which issues function codes, drives or samples the data
 * lines and returns captured data and initialization state.
 * Assumes the core holds cmd_* stable only for the accepting cycle.
 */
// Notes on behaviour
// - 16 data lines, four code lines, strobe
// - Data polarity chosen at initialization
// - Code lines always carry one code
// - Op bits 5-7, function 8-9, device rest
// - Function field selects go, clear, pulse codes
// - Skip and interrupt acknowledge issue nothing
// - Load codes drive lines, read codes sample
// - Read B ignored with internal registers
// - Init code captures device code and enables
// - Init bits always read negative logic
// - Mask code captures mask bit
// - Channel address captures direction, maybe address
// - Channel in samples, channel out drives
// - Block end code on count overflow
// - Idle code when nothing happens
// - Codes valid low, one strobe each
// - Input sampled at strobe rising edge
// - Strobe period is four master clocks
// - Direction one means in, zero out
`timescale 1ns/100ps
`default_nettype none

module periph_port (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       clk_link,
   input  wire logic                       cmd_valid,
   output var  logic                       cmd_ready,
   input  wire periph_port_pkg::cmd_kind_t cmd_kind,
   input  wire logic [15:0]                cmd_instr,
   input  wire logic [15:0]                cmd_wdata,
   output var  logic                       cmd_done,
   output var  logic [15:0]                rd_data,
   output var  logic                       rd_valid,
   output var  logic [4:0]                 device_select_code,
   output var  logic                       polarity_negative,
   output var  logic                       external_register_select,
   output var  logic                       external_flag_logic_select,
   output var  logic                       mask_bit,
   output var  logic                       channel_dir_in,
   output var  logic [14:0]                channel_addr,
   input  wire logic [15:0]                d_i,
   output var  logic [15:0]                d_o,
   output var  logic [15:0]                d_oe_n,
   output var  logic [3:0]                 function_code,
   output var  logic                       function_strobe
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic                       ready;
      logic                       req_tgl;
      periph_port_pkg::cmd_kind_t kind;
      logic [15:0]                instr;
      logic [15:0]                wdata;
      logic                       done;
      logic [15:0]                rd;
      logic                       rd_valid;
      logic [4:0]                 dev;
      logic                       neg;
      logic                       ext_reg;
      logic                       ext_flag;
      logic                       mask;
      logic                       dir_in;
      logic [14:0]                addr;
   } sys_t;

   typedef struct packed {
      periph_port_pkg::link_state_t state;
      logic                         ack_tgl;
      logic [3:0]                   code;
      logic [3:0]                   fcode;
      logic [1:0]                   fn;
      logic [15:0]                  dout;
      logic [15:0]                  oe_n;
      logic [15:0]                  sync1;
      logic [15:0]                  sync2;
      logic [15:0]                  sync3;
      logic [15:0]                  filt;
      logic [15:0]                  rd;
      logic [4:0]                   dev;
      logic                         neg;
      logic                         ext_reg;
      logic                         ext_flag;
      logic                         mask;
      logic                         dir_in;
      logic [14:0]                  addr;
   } link_t;

   sys_t  s_q;
   sys_t  s_d;
   link_t l_q;
   link_t l_d;

   logic link_rst_n;
   logic req_lvl;
   logic ack_lvl;

   strobe_if ph ();

   // ************************************************************
   // Clock crossings
   // ************************************************************
   level_sync u_rst_sync (
      .clk   (clk_link),
      .rst_n (1'b1),
      .din   (rst_n),
      .dout  (link_rst_n)
   );

   level_sync u_req_sync (
      .clk   (clk_link),
      .rst_n (link_rst_n),
      .din   (s_q.req_tgl),
      .dout  (req_lvl)
   );

   level_sync u_ack_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .din   (l_q.ack_tgl),
      .dout  (ack_lvl)
   );

   strobe_gen u_gen (
      .clk   (clk_link),
      .rst_n (link_rst_n),
      .ph    (ph)
   );

   // ************************************************************
   // Core side
   // ************************************************************
   always_comb begin
      s_d          = s_q;
      s_d.done     = 1'b0;
      s_d.rd_valid = 1'b0;
      if (s_q.ready && cmd_valid) begin
         s_d.ready   = 1'b0;
         s_d.req_tgl = ~s_q.req_tgl;
         s_d.kind    = cmd_kind;
         s_d.instr   = cmd_instr;
         s_d.wdata   = cmd_wdata;
      end else if (!s_q.ready && (ack_lvl == s_q.req_tgl)) begin
         // Link fields are quiet until the next request toggles
         s_d.ready    = 1'b1;
         s_d.done     = 1'b1;
         s_d.rd       = l_q.rd;
         s_d.dev      = l_q.dev;
         s_d.neg      = l_q.neg;
         s_d.ext_reg  = l_q.ext_reg;
         s_d.ext_flag = l_q.ext_flag;
         s_d.mask     = l_q.mask;
         s_d.dir_in   = l_q.dir_in;
         s_d.addr     = l_q.addr;
         if (s_q.kind == periph_port_pkg::CMD_INSTR) begin
            case (s_q.instr[periph_port_pkg::OP_MSB:periph_port_pkg::OP_LSB])
               periph_port_pkg::READ_A_OP,
               periph_port_pkg::READ_B_OP,
               periph_port_pkg::READ_C_OP: s_d.rd_valid = 1'b1;
               default:                    s_d.rd_valid = 1'b0;
            endcase
         end else if (s_q.kind == periph_port_pkg::CMD_CHAN_XFER) begin
            s_d.rd_valid = l_q.dir_in;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_q          <= '0;
         s_q.ready    <= 1'b1;
         s_q.kind     <= periph_port_pkg::CMD_INSTR;
         s_q.neg      <= periph_port_pkg::POLARITY_RST;
         s_q.dev      <= periph_port_pkg::DEVICE_SELECT_CODE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Link side sequencer
   // ************************************************************
   always_comb begin
      logic [15:0] val;
      logic [15:0] ini;
      logic [2:0]  op;
      logic        finish;
      val    = '0;
      ini    = '0;
      op     = '0;
      finish = 1'b0;
      l_d    = l_q;
      l_d.sync1 = d_i;
      l_d.sync2 = l_q.sync1;
      l_d.sync3 = l_q.sync2;
      l_d.filt  = (l_q.sync2 & l_q.sync3) | (l_q.filt & (l_q.sync2 ^ l_q.sync3));
      val = l_q.neg ? ~l_d.filt : l_d.filt;
      ini = ~l_d.filt;
      op  = s_q.instr[periph_port_pkg::OP_MSB:periph_port_pkg::OP_LSB];
      if (ph.tick) begin
         case (l_q.code)
            periph_port_pkg::READ_REG_A_CODE,
            periph_port_pkg::READ_REG_C_CODE,
            periph_port_pkg::CHANNEL_IN_CODE: l_d.rd = val;
            periph_port_pkg::READ_REG_B_CODE: l_d.rd = l_q.ext_reg ? val : '0;
            periph_port_pkg::PORT_INIT_CODE: begin
               l_d.dev      = ini[periph_port_pkg::DEVICE_SELECT_CODE_MSB:0];
               l_d.neg      = ini[periph_port_pkg::POLARITY_POS];
               l_d.ext_reg  = ini[periph_port_pkg::EXT_REG_POS];
               l_d.ext_flag = ini[periph_port_pkg::EXT_FLAG_POS];
            end
            periph_port_pkg::INTERRUPT_MASK_CODE: l_d.mask = val[periph_port_pkg::MASK_POS];
            periph_port_pkg::CHANNEL_ADDRESS_CODE: begin
               l_d.dir_in = val[periph_port_pkg::DIR_POS];
               if (l_q.ext_reg) begin
                  l_d.addr = val[periph_port_pkg::ADDR_MSB:0];
               end
            end
            default: l_d.rd = l_q.rd;
         endcase
         l_d.code = periph_port_pkg::IDLE_CODE;
         l_d.oe_n = '1;
         case (l_q.state)
            periph_port_pkg::LS_IDLE: begin
               if (req_lvl != l_q.ack_tgl) begin
                  l_d.state = periph_port_pkg::LS_DATA;
                  l_d.fn    = periph_port_pkg::FN_NONE;
                  case (s_q.kind)
                     periph_port_pkg::CMD_INSTR: begin
                        l_d.fn = s_q.instr[periph_port_pkg::FN_MSB:periph_port_pkg::FN_LSB];
                        case (op)
                           periph_port_pkg::READ_A_OP: l_d.code = periph_port_pkg::READ_REG_A_CODE;
                           periph_port_pkg::LOAD_A_OP: l_d.code = periph_port_pkg::LOAD_REG_A_CODE;
                           periph_port_pkg::READ_B_OP: l_d.code = periph_port_pkg::READ_REG_B_CODE;
                           periph_port_pkg::LOAD_B_OP: l_d.code = periph_port_pkg::LOAD_REG_B_CODE;
                           periph_port_pkg::READ_C_OP: l_d.code = periph_port_pkg::READ_REG_C_CODE;
                           periph_port_pkg::LOAD_C_OP: l_d.code = periph_port_pkg::LOAD_REG_C_CODE;
                           periph_port_pkg::SKIP_OP:   finish   = 1'b1;
                           default:                    l_d.code = periph_port_pkg::IDLE_CODE;
                        endcase
                        if (op == periph_port_pkg::LOAD_A_OP || op == periph_port_pkg::LOAD_B_OP ||
                            op == periph_port_pkg::LOAD_C_OP) begin
                           l_d.dout = l_q.neg ? ~s_q.wdata : s_q.wdata;
                           l_d.oe_n = '0;
                        end
                     end
                     periph_port_pkg::CMD_INIT:      l_d.code = periph_port_pkg::PORT_INIT_CODE;
                     periph_port_pkg::CMD_MASK:      l_d.code = periph_port_pkg::INTERRUPT_MASK_CODE;
                     periph_port_pkg::CMD_CHAN_ADDR: l_d.code = periph_port_pkg::CHANNEL_ADDRESS_CODE;
                     periph_port_pkg::CMD_CHAN_XFER: begin
                        if (l_q.dir_in) begin
                           l_d.code = periph_port_pkg::CHANNEL_IN_CODE;
                        end else begin
                           l_d.code = periph_port_pkg::CHANNEL_OUT_CODE;
                           l_d.dout = l_q.neg ? ~s_q.wdata : s_q.wdata;
                           l_d.oe_n = '0;
                        end
                     end
                     periph_port_pkg::CMD_BLOCK_END: l_d.code = periph_port_pkg::BLOCK_END_CODE;
                     default: finish = 1'b1;
                  endcase
                  if (finish) begin
                     l_d.state = periph_port_pkg::LS_IDLE;
                     l_d.fn    = periph_port_pkg::FN_NONE;
                  end
               end
            end
            periph_port_pkg::LS_DATA: begin
               // pulse code in next strobe cycle
               case (l_q.fn)
                  periph_port_pkg::FN_GO:    l_d.code = periph_port_pkg::DEVICE_GO_PULSE;
                  periph_port_pkg::FN_CLEAR: l_d.code = periph_port_pkg::DEVICE_CLEAR_PULSE;
                  periph_port_pkg::FN_PULSE: l_d.code = periph_port_pkg::DEVICE_GENERIC_PULSE;
                  default:                   finish   = 1'b1;
               endcase
               l_d.state = finish ? periph_port_pkg::LS_IDLE : periph_port_pkg::LS_PULSE;
            end
            default: begin
               finish    = 1'b1;
               l_d.state = periph_port_pkg::LS_IDLE;
            end
         endcase
         if (finish) begin
            l_d.ack_tgl = ~l_q.ack_tgl;
         end
      end
      l_d.fcode = {l_d.code[0], l_d.code[1], l_d.code[2], l_d.code[3]};
   end

   // code changes at the rise, one strobe each
   always_ff @(posedge clk_link) begin
      if (!link_rst_n) begin
         l_q       <= '0;
         l_q.state <= periph_port_pkg::LS_IDLE;
         l_q.code  <= periph_port_pkg::IDLE_CODE;
         l_q.fcode <= periph_port_pkg::IDLE_CODE;
         l_q.oe_n  <= '1;
         l_q.neg   <= periph_port_pkg::POLARITY_RST;
         l_q.dev   <= periph_port_pkg::DEVICE_SELECT_CODE_RST;
      end else begin
         l_q <= l_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign cmd_ready                  = s_q.ready;
   assign cmd_done                   = s_q.done;
   assign rd_data                    = s_q.rd;
   assign rd_valid                   = s_q.rd_valid;
   assign device_select_code         = s_q.dev;
   assign polarity_negative          = s_q.neg;
   assign external_register_select   = s_q.ext_reg;
   assign external_flag_logic_select = s_q.ext_flag;
   assign mask_bit                   = s_q.mask;
   assign channel_dir_in             = s_q.dir_in;
   assign channel_addr               = s_q.addr;
   assign d_o                        = l_q.dout;
   assign d_oe_n                     = l_q.oe_n;
   assign function_code              = l_q.fcode;
   assign function_strobe            = ph.strobe;

endmodule : periph_port

`default_nettype wire

// ==== src/periph_port_pkg.sv ====
/*
 * Constants and types shared by the peripheral port block: function codes,
 * instruction field positions, data line positions and command kinds.
 * Assumes vectors are numbered msb-first: documented bit or line n sits at
 * vector index 15-n.
 */
package periph_port_pkg;

   // ************************************************************
   // Strobe timing, in master (link) clock periods
   // ************************************************************
   localparam int unsigned STROBE_DIV       = 4;
   localparam logic [1:0]  STROBE_RISE_CNT  = 2'h2;
   localparam logic [1:0]  TICK_CNT         = 2'h1;

   // ************************************************************
   // Function codes, printed left to right as bit 3 down to bit 0
   // ************************************************************
   localparam logic [3:0] LOAD_REG_A_CODE      = 4'h0;
   localparam logic [3:0] READ_REG_A_CODE      = 4'h1;
   localparam logic [3:0] LOAD_REG_B_CODE      = 4'h2;
   localparam logic [3:0] READ_REG_B_CODE      = 4'h3;
   localparam logic [3:0] LOAD_REG_C_CODE      = 4'h4;
   localparam logic [3:0] READ_REG_C_CODE      = 4'h5;
   localparam logic [3:0] DEVICE_GO_PULSE      = 4'h6;
   localparam logic [3:0] DEVICE_CLEAR_PULSE   = 4'h7;
   localparam logic [3:0] DEVICE_GENERIC_PULSE = 4'h8;
   localparam logic [3:0] PORT_INIT_CODE       = 4'h9;
   localparam logic [3:0] INTERRUPT_MASK_CODE  = 4'hA;
   localparam logic [3:0] CHANNEL_ADDRESS_CODE = 4'hB;
   localparam logic [3:0] CHANNEL_IN_CODE      = 4'hC;
   localparam logic [3:0] CHANNEL_OUT_CODE     = 4'hD;
   localparam logic [3:0] BLOCK_END_CODE       = 4'hE;
   localparam logic [3:0] IDLE_CODE            = 4'hF;

   // ************************************************************
   // Instruction word fields
   // ************************************************************
   localparam int unsigned OP_MSB  = 10;
   localparam int unsigned OP_LSB  = 8;
   localparam int unsigned FN_MSB  = 7;
   localparam int unsigned FN_LSB  = 6;

   localparam logic [2:0] NO_TRANSFER_OP = 3'h0;
   localparam logic [2:0] READ_A_OP      = 3'h1;
   localparam logic [2:0] LOAD_A_OP      = 3'h2;
   localparam logic [2:0] READ_B_OP      = 3'h3;
   localparam logic [2:0] LOAD_B_OP      = 3'h4;
   localparam logic [2:0] READ_C_OP      = 3'h5;
   localparam logic [2:0] LOAD_C_OP      = 3'h6;
   localparam logic [2:0] SKIP_OP        = 3'h7;

   localparam logic [1:0] FN_NONE  = 2'h0;
   localparam logic [1:0] FN_GO    = 2'h1;
   localparam logic [1:0] FN_CLEAR = 2'h2;
   localparam logic [1:0] FN_PULSE = 2'h3;

   // ************************************************************
   // Data line positions (vector index)
   // ************************************************************
   localparam int unsigned DEVICE_SELECT_CODE_MSB  = 4;
   localparam int unsigned POLARITY_POS  = 6;
   localparam int unsigned EXT_REG_POS   = 7;
   localparam int unsigned EXT_FLAG_POS  = 8;
   localparam int unsigned MASK_POS      = 15;
   localparam int unsigned DIR_POS       = 15;
   localparam int unsigned ADDR_MSB      = 14;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic       POLARITY_RST  = 1'b0;
   localparam logic [4:0] DEVICE_SELECT_CODE_RST  = 5'h00;

   // ************************************************************
   // Command kinds and link sequencer states
   // ************************************************************
   typedef enum logic [2:0] {
      CMD_INSTR, CMD_INT_ACK, CMD_INIT, CMD_MASK,
      CMD_CHAN_ADDR, CMD_CHAN_XFER, CMD_BLOCK_END
   } cmd_kind_t;

   typedef enum logic [1:0] {
      LS_IDLE, LS_DATA, LS_PULSE
   } link_state_t;

endpackage : periph_port_pkg

// ==== src/strobe_gen.sv ====
/*
 * Function strobe generator: divides the link clock by four, low for the
 * first two counts and high for the last two. Tick marks the cycle before
 * the strobe rises, when the sequencer samples and loads the next code.
 */
`timescale 1ns/100ps
`default_nettype none

module strobe_gen (
   input  wire logic clk,
   input  wire logic rst_n,
   strobe_if.drive   ph
);

   typedef struct packed {
      logic [1:0] cnt;
      logic       strobe;
      logic       tick;
   } gen_t;

   gen_t q;
   gen_t d;

   always_comb begin
      d        = q;
      d.cnt    = q.cnt + 2'h1;
      d.strobe = (d.cnt >= periph_port_pkg::STROBE_RISE_CNT);
      d.tick   = (d.cnt == periph_port_pkg::TICK_CNT);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ph.strobe = q.strobe;
   assign ph.tick   = q.tick;

endmodule : strobe_gen

`default_nettype wire

// ==== src/strobe_if.sv ====
/*
 * Carries the function strobe and its code-load tick from the strobe
 * generator to the port sequencer. Both ends run on the link clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface strobe_if;
   logic strobe;
   logic tick;

   modport drive (output strobe, output tick);
   modport use_  (input  strobe, input  tick);
endinterface : strobe_if

`default_nettype wire
